// *** verilog/supply_monitor_pkg.sv ***
// Constants for the dual-rail supply monitor: register map, field
// layout, reset value, trip codes and timing counts.
// Assumes a 250 MHz core clock.
`default_nettype none

package supply_monitor_pkg;

  // Register address on the core's internal register bus
  localparam logic [7:0] SUPPLY_MONITOR_CONTROL_ADDR = 8'hdf;
  localparam logic [7:0] SUPPLY_MONITOR_CONTROL_RESET = 8'hde;

  // Field positions in supply_monitor_control
  localparam int DIGITAL_CMP_BIT = 7;
  localparam int ANALOG_CMP_BIT = 6;
  localparam int LOW_FLAG_BIT = 5;
  localparam int DIGITAL_TRIP_LSB = 3;
  localparam int ANALOG_TRIP_LSB = 1;
  localparam int ENABLE_BIT = 0;

  // Trip select codes, named by the trip voltage they pick
  localparam logic [1:0] TRIP_4V63 = 2'h0;
  localparam logic [1:0] TRIP_3V08 = 2'h1;
  localparam logic [1:0] TRIP_2V93 = 2'h2;
  localparam logic [1:0] TRIP_2V63 = 2'h3;

  // Timing
  localparam int CLK_PERIOD_PS = 4000;
  localparam int FILTER_TIME_NS = 100;
  localparam int FILTER_CYCLES =
    (FILTER_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int TICK_TIME_US = 1000;
  localparam int TICK_CYCLES = TICK_TIME_US * 1000000 / CLK_PERIOD_PS;
  localparam int QUAL_TIME_MS = 250;
  localparam int QUAL_TICKS = QUAL_TIME_MS * 1000 / TICK_TIME_US;

  // Counter widths
  localparam int FILT_W = 5;
  localparam int TICK_W = 18;
  localparam int QUAL_W = 8;

  typedef enum logic [1:0] {
    PH_IDLE,
    PH_LOW,
    PH_QUALIFY
  } phase_e;

endpackage

`default_nettype wire

// *** verilog/supply_monitor_interrupt.sv ***
// Digital side of the dual-rail supply monitor: control register,
// comparator glitch filters, low-supply flag and 250 ms qualification.
// Assumes comparator outputs and register bus signals are synchronous
// to clk; the interrupt enable bit comes from the core's enable register.
//
// Contract
// - Once enabled, watch both rails against one of four trip levels.
// - Interrupt request only while the flag's enable bit is set.
// - Flag stays set until supplies are good for 250 ms or software clears it.
// - Comparator outputs are filtered so short glitches are ignored.
// - Bit 7 is read-only and shows the digital rail comparator.
// - Bit 6 is read-only and shows the analog rail comparator.
// - Flag in bit 5 sets whenever either filtered comparator is low while the monitor is enabled.
// - Both rails high and steady start 250 ms count; expiry clears flag.
// - Software may write the flag; clears are ignored while a rail is low.
// - Bits 4:3 select the digital rail trip point.
// - Trip codes: 00 4.63 V, 01 3.08 V, 10 2.93 V, 11 2.63 V.
// - Bit 0 enables the monitor when set, disables when cleared.
`timescale 1ns/100ps
`default_nettype none

module supply_monitor_interrupt
  import supply_monitor_pkg::*;
#(
  parameter int TICK_COUNT = TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic digital_rail_compare_in,
  input wire logic analog_rail_compare_in,
  input wire logic low_supply_irq_enable,
  output logic supply_monitor_enable,
  output logic [1:0] digital_rail_trip_select,
  output logic [1:0] analog_rail_trip_select,
  output logic low_supply_irq
);

  typedef struct packed {
    logic dig_cmp;
    logic ana_cmp;
    logic dig_ok;
    logic ana_ok;
    logic [FILT_W-1:0] dig_cnt;
    logic [FILT_W-1:0] ana_cnt;
    logic flag;
    logic [1:0] tpd;
    logic [1:0] tpa;
    logic en;
    phase_e phase;
    logic [TICK_W-1:0] tick_cnt;
    logic [QUAL_W-1:0] qual_cnt;
    logic irq;
    logic [7:0] rdata;
  } state_s;

  localparam state_s STATE_RESET = '{
    dig_cmp: SUPPLY_MONITOR_CONTROL_RESET[DIGITAL_CMP_BIT],
    ana_cmp: SUPPLY_MONITOR_CONTROL_RESET[ANALOG_CMP_BIT],
    dig_ok: 1'b1,
    ana_ok: 1'b1,
    dig_cnt: '0,
    ana_cnt: '0,
    flag: SUPPLY_MONITOR_CONTROL_RESET[LOW_FLAG_BIT],
    tpd: SUPPLY_MONITOR_CONTROL_RESET[DIGITAL_TRIP_LSB +: 2],
    tpa: SUPPLY_MONITOR_CONTROL_RESET[ANALOG_TRIP_LSB +: 2],
    en: SUPPLY_MONITOR_CONTROL_RESET[ENABLE_BIT],
    phase: PH_IDLE,
    tick_cnt: '0,
    qual_cnt: '0,
    irq: 1'b0,
    rdata: 8'h00
  };

  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_COUNT - 1);
  localparam logic [QUAL_W-1:0] QUAL_LAST = QUAL_W'(QUAL_TICKS - 1);
  localparam logic [FILT_W-1:0] FILT_LAST = FILT_W'(FILTER_CYCLES - 1);

  state_s st_q;
  state_s st_d;
  logic ctrl_wr;
  logic both_ok;
  logic tick;

  // Glitch filter: follow a new level only after it held FILTER_CYCLES
  function automatic logic [FILT_W:0] filter_step(
    input logic raw,
    input logic ok,
    input logic [FILT_W-1:0] cnt
  );
    logic [FILT_W:0] r;
    r = {ok, {FILT_W{1'b0}}};
    if (raw != ok) begin
      if (cnt == FILT_LAST) begin
        r = {raw, {FILT_W{1'b0}}};
      end else begin
        r = {ok, FILT_W'(cnt + 1'b1)};
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] control_value(input state_s s);
    logic [7:0] v;
    v = 8'h00;
    v[DIGITAL_CMP_BIT] = s.dig_cmp;
    v[ANALOG_CMP_BIT] = s.ana_cmp;
    v[LOW_FLAG_BIT] = s.flag;
    v[DIGITAL_TRIP_LSB +: 2] = s.tpd;
    v[ANALOG_TRIP_LSB +: 2] = s.tpa;
    v[ENABLE_BIT] = s.en;
    return v;
  endfunction

  assign ctrl_wr = sfr_wr && (sfr_addr == SUPPLY_MONITOR_CONTROL_ADDR);
  assign both_ok = st_q.dig_ok && st_q.ana_ok;
  assign tick = (st_q.phase == PH_QUALIFY) && (st_q.tick_cnt == TICK_LAST);

  always_comb begin
    st_d = st_q;
    st_d.dig_cmp = digital_rail_compare_in;
    st_d.ana_cmp = analog_rail_compare_in;
    // filtered rail states drive the flag; disabled reads as good
    if (st_q.en) begin
      {st_d.dig_ok, st_d.dig_cnt} =
        filter_step(st_q.dig_cmp, st_q.dig_ok, st_q.dig_cnt);
      {st_d.ana_ok, st_d.ana_cnt} =
        filter_step(st_q.ana_cmp, st_q.ana_ok, st_q.ana_cnt);
    end else begin
      st_d.dig_ok = 1'b1;
      st_d.ana_ok = 1'b1;
      st_d.dig_cnt = '0;
      st_d.ana_cnt = '0;
    end
    if (ctrl_wr) begin
      st_d.tpd = sfr_wdata[DIGITAL_TRIP_LSB +: 2];
      st_d.tpa = sfr_wdata[ANALOG_TRIP_LSB +: 2];
      st_d.en = sfr_wdata[ENABLE_BIT];
    end
    // qualification sequence on the 1 ms time base
    st_d.tick_cnt = '0;
    st_d.qual_cnt = '0;
    case (st_q.phase)
      PH_IDLE: begin
        if (!both_ok) begin
          st_d.phase = PH_LOW;
        end else if (st_q.flag) begin
          st_d.phase = PH_QUALIFY;
        end
      end
      PH_LOW: begin
        if (both_ok) begin
          st_d.phase = st_q.flag ? PH_QUALIFY : PH_IDLE;
        end
      end
      PH_QUALIFY: begin
        if (!both_ok) begin
          st_d.phase = PH_LOW;
        end else if (!st_q.flag) begin
          st_d.phase = PH_IDLE;
        end else if (tick) begin
          st_d.qual_cnt = QUAL_W'(st_q.qual_cnt + 1'b1);
          if (st_q.qual_cnt == QUAL_LAST) begin
            st_d.phase = PH_IDLE;
            st_d.qual_cnt = '0;
          end
        end else begin
          st_d.tick_cnt = TICK_W'(st_q.tick_cnt + 1'b1);
          st_d.qual_cnt = st_q.qual_cnt;
        end
      end
      default: begin
        st_d.phase = PH_IDLE;
      end
    endcase
    if ((st_q.phase == PH_QUALIFY) && both_ok && tick &&
        (st_q.qual_cnt == QUAL_LAST)) begin
      st_d.flag = 1'b0;
    end
    // software writes; a clear only lands while both rails are good
    if (ctrl_wr && (sfr_wdata[LOW_FLAG_BIT] || both_ok)) begin
      st_d.flag = sfr_wdata[LOW_FLAG_BIT];
    end
    // a low rail sets the flag, winning over any clear
    if (st_q.en && !both_ok) begin
      st_d.flag = 1'b1;
    end
    // request gated by the enable bit
    st_d.irq = st_q.flag && low_supply_irq_enable;
    st_d.rdata = 8'h00;
    if (sfr_rd && (sfr_addr == SUPPLY_MONITOR_CONTROL_ADDR)) begin
      st_d.rdata = control_value(st_q);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= STATE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign sfr_rdata = st_q.rdata;
  assign supply_monitor_enable = st_q.en;
  assign digital_rail_trip_select = st_q.tpd;
  assign analog_rail_trip_select = st_q.tpa;
  assign low_supply_irq = st_q.irq;

  property p_digital_status;
    @(posedge clk) disable iff (reset)
      (sfr_rd && sfr_addr == SUPPLY_MONITOR_CONTROL_ADDR) |=>
        sfr_rdata[DIGITAL_CMP_BIT] == $past(digital_rail_compare_in, 2);
  endproperty
  a_digital_status: assert property (p_digital_status)
    else $error("digital comparator bit does not follow the rail");

  property p_analog_status;
    @(posedge clk) disable iff (reset)
      (sfr_rd && sfr_addr == SUPPLY_MONITOR_CONTROL_ADDR) |=>
        sfr_rdata[ANALOG_CMP_BIT] == $past(analog_rail_compare_in, 2);
  endproperty
  a_analog_status: assert property (p_analog_status)
    else $error("analog comparator bit does not follow the rail");

  property p_low_sets_flag;
    @(posedge clk) disable iff (reset)
      (st_q.en && !both_ok) |=> st_q.flag;
  endproperty
  a_low_sets_flag: assert property (p_low_sets_flag)
    else $error("low rail did not set the flag");

  property p_irq_gate;
    @(posedge clk) disable iff (reset)
      !reset |=>
        (low_supply_irq == $past(st_q.flag && low_supply_irq_enable));
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt request not gated by its enable");

  property p_irq_blocked;
    @(posedge clk) disable iff (reset)
      !low_supply_irq_enable |=> !low_supply_irq;
  endproperty
  a_irq_blocked: assert property (p_irq_blocked)
    else $error("interrupt request raised while disabled");

  property p_clear_refused;
    @(posedge clk) disable iff (reset)
      (ctrl_wr && !sfr_wdata[LOW_FLAG_BIT] && st_q.en && !both_ok)
        |=> st_q.flag;
  endproperty
  a_clear_refused: assert property (p_clear_refused)
    else $error("flag cleared while a rail was low");

  property p_fall_needs_good;
    @(posedge clk) disable iff (reset)
      $fell(st_q.flag) |-> $past(both_ok);
  endproperty
  a_fall_needs_good: assert property (p_fall_needs_good)
    else $error("flag cleared without good rails");

  property p_expiry_clears;
    @(posedge clk) disable iff (reset)
      (st_q.phase == PH_QUALIFY && both_ok && tick &&
       st_q.qual_cnt == QUAL_LAST && !ctrl_wr) |=> !st_q.flag;
  endproperty
  a_expiry_clears: assert property (p_expiry_clears)
    else $error("qualification expiry did not clear the flag");

  property p_restart;
    @(posedge clk) disable iff (reset)
      (st_q.phase == PH_QUALIFY && !both_ok) |=>
        (st_q.qual_cnt == '0 && st_q.tick_cnt == '0);
  endproperty
  a_restart: assert property (p_restart)
    else $error("qualification count not restarted by a low rail");

  property p_filter;
    @(posedge clk) disable iff (reset)
      $fell(st_q.dig_ok) |-> $past(st_q.dig_cmp == 1'b0, 1) &&
        $past(st_q.dig_cmp == 1'b0, 2) && $past(st_q.dig_cmp == 1'b0, 3);
  endproperty
  a_filter: assert property (p_filter)
    else $error("digital rail filter passed a glitch");

  property p_trip_write;
    @(posedge clk) disable iff (reset)
      ctrl_wr |=> (digital_rail_trip_select ==
        $past(sfr_wdata[DIGITAL_TRIP_LSB +: 2])) &&
        (supply_monitor_enable == $past(sfr_wdata[ENABLE_BIT]));
  endproperty
  a_trip_write: assert property (p_trip_write)
    else $error("control write not applied");

  property p_disabled_quiet;
    @(posedge clk) disable iff (reset)
      (!st_q.en && !st_q.flag && !ctrl_wr) |=> !st_q.flag;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet)
    else $error("flag set while the monitor was disabled");

endmodule

`default_nettype wire

// *** dv/rail_comparator_model.sv ***
// Behavioural model of the two analog supply comparators.
// Assumes the bench sets each rail level in millivolts between edges.
`timescale 1ns/100ps
`default_nettype none

module rail_comparator_model (
  input wire logic [1:0] digital_rail_trip_select,
  input wire logic [1:0] analog_rail_trip_select,
  input var int digital_mv,
  input var int analog_mv,
  output logic digital_rail_compare_in,
  output logic analog_rail_compare_in
);
  function automatic int trip_mv(input logic [1:0] code);
    case (code)
      2'h0: trip_mv = 4630;
      2'h1: trip_mv = 3080;
      2'h2: trip_mv = 2930;
      default: trip_mv = 2630;
    endcase
  endfunction

  assign digital_rail_compare_in =
    digital_mv > trip_mv(digital_rail_trip_select);
  assign analog_rail_compare_in =
    analog_mv > trip_mv(analog_rail_trip_select);
endmodule

`default_nettype wire

// *** dv/supply_monitor_interrupt_tb_top.sv ***
// Self-checking bench for the supply monitor block.
// Assumes the comparator model on the rails and a short tick parameter.
`timescale 1ns/100ps
`default_nettype none

module supply_monitor_interrupt_tb_top;
  import supply_monitor_pkg::*;
  localparam int TICKS = 4;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic irq_en = 1'b0;
  logic [7:0] sfr_rdata;
  logic dig_cmp, ana_cmp, mon_en, irq;
  logic [1:0] dig_trip, ana_trip;
  int dig_mv = 5000;
  int ana_mv = 5000;
  int err_count = 0;
  int checks_done = 0;

  initial begin
    forever #2 clk = ~clk;
  end

  supply_monitor_interrupt #(.TICK_COUNT(TICKS)) u_dut (
    .clk(clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .digital_rail_compare_in(dig_cmp), .analog_rail_compare_in(ana_cmp),
    .low_supply_irq_enable(irq_en), .supply_monitor_enable(mon_en),
    .digital_rail_trip_select(dig_trip), .analog_rail_trip_select(ana_trip),
    .low_supply_irq(irq));

  rail_comparator_model u_rails (
    .digital_rail_trip_select(dig_trip), .analog_rail_trip_select(ana_trip),
    .digital_mv(dig_mv), .analog_mv(ana_mv),
    .digital_rail_compare_in(dig_cmp), .analog_rail_compare_in(ana_cmp));

  task automatic final_report;
    $display("Checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] exp,
                       input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic cycles(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic reg_write(input logic [7:0] addr, input logic [7:0] data);
    sfr_addr = addr;
    sfr_wdata = data;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic reg_read(input logic [7:0] addr, input logic [7:0] exp,
                          input string name);
    sfr_addr = addr;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    check(name, exp, sfr_rdata);
    @(negedge clk);
  endtask

  task automatic s_reset;
    reg_read(SUPPLY_MONITOR_CONTROL_ADDR, 8'hde, "reset_value");
    check("reset_ports", 8'h1e,
      {3'h0, dig_trip, ana_trip, mon_en | irq});
    reg_write(8'hde, 8'h01);
    reg_read(8'hde, 8'h00, "unmapped_read");
    reg_read(SUPPLY_MONITOR_CONTROL_ADDR, 8'hde, "unmapped_write");
  endtask

  task automatic s_trip;
    logic [1:0] c;
    dig_mv = 3000;
    ana_mv = 3100;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      reg_write(SUPPLY_MONITOR_CONTROL_ADDR, {3'h0, c, c, 1'b0});
      cycles(3);
      check("trip_ports", {4'h0, c, c}, {4'h0, dig_trip, ana_trip});
      reg_read(SUPPLY_MONITOR_CONTROL_ADDR,
        {i >= 2, i >= 1, 1'b0, c, c, 1'b0}, "trip_status");
    end
    dig_mv = 5000;
    ana_mv = 5000;
    cycles(3);
  endtask

  task automatic s_low;
    reg_write(SUPPLY_MONITOR_CONTROL_ADDR, 8'h01);
    check("enable_port", 8'h01, {7'h0, mon_en});
    ana_mv = 3000;
    cycles(40);
    check("irq_masked", 8'h00, {7'h0, irq});
    reg_read(SUPPLY_MONITOR_CONTROL_ADDR, 8'ha1, "flag_set");
    reg_write(SUPPLY_MONITOR_CONTROL_ADDR, 8'hc1);
    reg_read(SUPPLY_MONITOR_CONTROL_ADDR, 8'ha1, "clear_refused");
    irq_en = 1'b1;
    cycles(2);
    check("irq_on", 8'h01, {7'h0, irq});
  endtask

  task automatic s_qual;
    int n;
    ana_mv = 5000;
    cycles(500);
    ana_mv = 3000;
    cycles(40);
    ana_mv = 5000;
    n = 0;
    while (irq !== 1'b0) begin
      @(negedge clk);
      n++;
      if (n > 1100) begin
        err_count++;
        $display("MISMATCH qual_wait expected drop seen none");
        final_report();
      end
    end
    check("qual_min", 8'h01, {7'h0, n >= 1000});
    check("qual_max", 8'h01, {7'h0, n <= 1060});
    reg_read(SUPPLY_MONITOR_CONTROL_ADDR, 8'hc1, "flag_cleared");
  endtask

  task automatic s_glitch;
    dig_mv = 4000;
    cycles(10);
    dig_mv = 5000;
    cycles(40);
    reg_read(SUPPLY_MONITOR_CONTROL_ADDR, 8'hc1, "glitch_flag");
    check("glitch_irq", 8'h00, {7'h0, irq});
    // A held drop of the digital rail must pass the filter
    dig_mv = 4000;
    cycles(40);
    reg_read(SUPPLY_MONITOR_CONTROL_ADDR, 8'h61, "digital_low");
    check("digital_irq", 8'h01, {7'h0, irq});
    dig_mv = 5000;
    cycles(40);
    reg_write(SUPPLY_MONITOR_CONTROL_ADDR, 8'h01);
    reg_read(SUPPLY_MONITOR_CONTROL_ADDR, 8'hc1, "digital_clear");
  endtask

  task automatic s_swclear;
    reg_write(SUPPLY_MONITOR_CONTROL_ADDR, 8'h21);
    cycles(2);
    check("sw_set_irq", 8'h01, {7'h0, irq});
    reg_write(SUPPLY_MONITOR_CONTROL_ADDR, 8'h01);
    reg_read(SUPPLY_MONITOR_CONTROL_ADDR, 8'hc1, "sw_clear");
    reg_write(SUPPLY_MONITOR_CONTROL_ADDR, 8'h00);
    dig_mv = 2000;
    cycles(40);
    reg_read(SUPPLY_MONITOR_CONTROL_ADDR, 8'h40, "disabled");
    check("disabled_ports", 8'h00, {6'h0, mon_en, irq});
  endtask

  initial begin
    cycles(8);
    reset = 1'b0;
    s_reset();
    s_trip();
    s_low();
    s_qual();
    s_glitch();
    s_swclear();
    final_report();
  end
endmodule

`default_nettype wire
